// [shared/ptddp_map.svh]
// constants of the training and deskew debug probe
// Overview of operation
// - flag lane after eight consecutive idle symbols in a config or recovery idle state
// - flag lane whose TS link field is PAD
// - flag lane whose TS lane field is PAD
// - count identical TS sets on logical lane zero
// - identical-set counter wraps to zero at maximum
// - negotiated width shown as one-hot code
// - three-bit deskew FIFO level per lane
// - per-lane deskew error flag on overflow
// - overflow reports port error and starts retraining
// - training state code on lowest five bits
`ifndef PTDDP_MAP_SVH
`define PTDDP_MAP_SVH
`define PTDDP_LANES        8
`define PTDDP_SYM_W        8
`define PTDDP_SIG_W        40
`define PTDDP_K_COM        8'hBC
`define PTDDP_K_PAD        8'hF7
`define PTDDP_D_IDLE       8'h00
`define PTDDP_TS1_ID       8'h4A
`define PTDDP_TS2_ID       8'h45
`define PTDDP_POS_LINK     4'h1
`define PTDDP_POS_LANE     4'h2
`define PTDDP_POS_SIG_END  4'h5
`define PTDDP_POS_ID       4'h6
`define PTDDP_POS_LAST     4'hF
`define PTDDP_IDLE_RUN     4'h8
`define PTDDP_ST_CFG_IDLE  5'h0B
`define PTDDP_ST_REC_IDLE  5'h0E
`define PTDDP_FIFO_DEPTH   3'h4
`define PTDDP_PTR_W        2
`define PTDDP_LVL_W        3
`define PTDDP_ENT_W        9
`define PTDDP_GAP_ZERO     43'h0
`define PTDDP_RSVD_ZERO    4'h0
`define PTDDP_FLD_STATE    0
`define PTDDP_FLD_IDLE_A   48
`define PTDDP_FLD_IDLE_B   56
`define PTDDP_FLD_LINKPAD  64
`define PTDDP_FLD_LANEPAD  72
`define PTDDP_FLD_TSNUM    80
`define PTDDP_FLD_WIDTH    88
`define PTDDP_FLD_LEVEL    96
`define PTDDP_FLD_DSKERR   120
`define PTDDP_REG_CTRL     4'h0
`define PTDDP_REG_ERR      4'h4
`define PTDDP_REG_STAT     4'h8
`define PTDDP_CTRL_RST     4'h8
`define PTDDP_CTRL_EN_BIT  3
`endif

// [shared/ptddp_pkg.sv]
// types of the training and deskew debug probe
`include "ptddp_map.svh"
package ptddp_pkg;
  typedef logic [`PTDDP_LANES-1:0]  ptddp_mask_t;
  typedef logic [`PTDDP_LVL_W-1:0]  ptddp_level_t;
  typedef logic [`PTDDP_SIG_W-1:0]  ptddp_sig_t;
  typedef logic [4:0]               ptddp_state_t;
  typedef logic [1:0]               ptddp_width_t;
  typedef enum logic {PTDDP_HUNT, PTDDP_BODY} ptddp_parse_e;
endpackage

// [rtl/ptddp_fifo_mem.sv]
// one lane's deskew storage with registered read data
`timescale 1ns/10ps
`include "ptddp_map.svh"
module ptddp_fifo_mem (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  // write side
  input  wire logic                        wr_en,
  input  wire logic [`PTDDP_PTR_W-1:0]     wr_addr,
  input  wire logic [`PTDDP_ENT_W-1:0]     wr_data,
  // read side
  input  wire logic                        rd_en,
  input  wire logic [`PTDDP_PTR_W-1:0]     rd_addr,
  output logic      [`PTDDP_ENT_W-1:0]     rd_data
);
  logic [`PTDDP_ENT_W-1:0] mem [0:(1<<`PTDDP_PTR_W)-1];

  // array left unreset so it maps onto plain storage
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // ptddp_fifo_mem

// [rtl/ptddp_lane_rx.sv]
// per-lane idle-run detector and training-set parser
`timescale 1ns/10ps
`include "ptddp_map.svh"
module ptddp_lane_rx (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  // received symbol
  input  wire logic                      sym_valid,
  input  wire logic [`PTDDP_SYM_W-1:0]   sym_data,
  input  wire logic                      sym_is_k,
  input  wire logic                      idle_win,
  // results
  output logic                           idle_seen,
  output logic                           ts_done,
  output logic                           link_pad,
  output logic                           lane_pad,
  output ptddp_pkg::ptddp_sig_t          ts_sig
);
  ptddp_pkg::ptddp_parse_e  st_r;
  logic [3:0]               pos_r;
  logic [3:0]               run_r;
  logic [`PTDDP_SYM_W-1:0]  id_r;
  logic                     id_ok_r;
  logic                     lpad_r;
  logic                     npad_r;
  ptddp_pkg::ptddp_sig_t    sig_r;

  wire is_com   = sym_valid && sym_is_k && (sym_data == `PTDDP_K_COM);
  wire is_pad   = sym_is_k && (sym_data == `PTDDP_K_PAD);
  wire is_idle  = !sym_is_k && (sym_data == `PTDDP_D_IDLE);
  wire id_legal = !sym_is_k && (sym_data == `PTDDP_TS1_ID || sym_data == `PTDDP_TS2_ID);
  wire id_match = (pos_r == `PTDDP_POS_ID) ? id_legal : (!sym_is_k && sym_data == id_r);
  wire last_sym = sym_valid && (st_r == ptddp_pkg::PTDDP_BODY) && (pos_r == `PTDDP_POS_LAST);

  // flag stays up for the rest of the idle state once seen
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_r     <= '0;
      idle_seen <= 1'b0;
    end else if (!idle_win) begin
      run_r     <= '0;
      idle_seen <= 1'b0;
    end else if (sym_valid) begin
      run_r <= is_idle ? ((run_r == `PTDDP_IDLE_RUN) ? run_r : run_r + 4'h1) : 4'h0;
      if (is_idle && run_r == `PTDDP_IDLE_RUN - 4'h1) begin
        idle_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= ptddp_pkg::PTDDP_HUNT;
      pos_r   <= '0;
      id_r    <= '0;
      id_ok_r <= 1'b0;
      lpad_r  <= 1'b0;
      npad_r  <= 1'b0;
      sig_r   <= '0;
    end else if (is_com) begin
      st_r    <= ptddp_pkg::PTDDP_BODY;
      pos_r   <= `PTDDP_POS_LINK;
      id_ok_r <= 1'b1;
    end else if (sym_valid) begin
      case (st_r)
        ptddp_pkg::PTDDP_BODY: begin
          pos_r <= pos_r + 4'h1;
          if (pos_r == `PTDDP_POS_LINK) begin
            lpad_r <= is_pad;
          end
          if (pos_r == `PTDDP_POS_LANE) begin
            npad_r <= is_pad;
          end
          if (pos_r <= `PTDDP_POS_SIG_END) begin
            sig_r <= {sig_r[`PTDDP_SIG_W-`PTDDP_SYM_W-1:0], sym_data};
          end
          if (pos_r == `PTDDP_POS_ID) begin
            id_r <= sym_data;
          end
          if (pos_r >= `PTDDP_POS_ID && !id_match) begin
            id_ok_r <= 1'b0;
          end
          if (pos_r == `PTDDP_POS_LAST) begin
            st_r <= ptddp_pkg::PTDDP_HUNT;
          end
        end
        default: st_r <= ptddp_pkg::PTDDP_HUNT;
      endcase
    end
  end

  // pad flags and signature only change at the end of a well-formed set, where ts_done pulses for one cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ts_done  <= 1'b0;
      link_pad <= 1'b0;
      lane_pad <= 1'b0;
      ts_sig   <= '0;
    end else begin
      ts_done <= last_sym && id_ok_r && id_match;
      if (last_sym && id_ok_r && id_match) begin
        link_pad <= lpad_r;
        lane_pad <= npad_r;
        ts_sig   <= sig_r;
      end
    end
  end
endmodule // ptddp_lane_rx

// [rtl/ptddp_top.sv]
// training and deskew debug probe: lanes, deskew FIFOs, test-out bus
`timescale 1ns/10ps
`include "ptddp_map.svh"
module ptddp_top (
  // clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 resetn,
  // register port
  input  wire logic [3:0]                           reg_addr,
  input  wire logic [31:0]                          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [31:0]                          reg_rdata,
  // training status from the link state machine
  input  wire ptddp_pkg::ptddp_state_t              ltssm_state,
  input  wire ptddp_pkg::ptddp_width_t              lane_width_code,
  // received symbols, lane n in slice n
  input  wire logic [`PTDDP_LANES-1:0]              sym_valid,
  input  wire logic [`PTDDP_LANES*`PTDDP_SYM_W-1:0] sym_data,
  input  wire logic [`PTDDP_LANES-1:0]              sym_is_k,
  // deskewed output
  output logic                                      dsk_valid,
  output logic [`PTDDP_LANES*`PTDDP_ENT_W-1:0]      dsk_data,
  // error events
  output logic                                      retrain_req,
  output logic                                      rx_port_err,
  // debug bus
  output logic [127:0]                              dbg_out
);
  localparam int NL = `PTDDP_LANES;

  function automatic logic [3:0] width_onehot(input ptddp_pkg::ptddp_width_t code);
    width_onehot = 4'h1 << code;
  endfunction

  function automatic ptddp_pkg::ptddp_level_t level_next(
    input ptddp_pkg::ptddp_level_t lvl,
    input logic                    wr,
    input logic                    rd
  );
    level_next = lvl;
    if (wr && !rd) begin
      level_next = lvl + 3'h1;
    end else if (rd && !wr) begin
      level_next = lvl - 3'h1;
    end
  endfunction

  logic [3:0]                  ctrl_r;
  ptddp_pkg::ptddp_mask_t      err_r;
  ptddp_pkg::ptddp_state_t     state_prev_r;
  logic [7:0]                  ts_cnt_r;
  ptddp_pkg::ptddp_sig_t       prev_sig_r;
  logic                        have_prev_r;
  ptddp_pkg::ptddp_level_t     lvl_r [NL];
  logic [`PTDDP_PTR_W-1:0]     wptr_r [NL];
  logic [`PTDDP_PTR_W-1:0]     rptr_r [NL];

  ptddp_pkg::ptddp_mask_t      idle_seen_w;
  ptddp_pkg::ptddp_mask_t      ts_done_w;
  ptddp_pkg::ptddp_mask_t      link_pad_w;
  ptddp_pkg::ptddp_mask_t      lane_pad_w;
  ptddp_pkg::ptddp_mask_t      ovf_w;
  ptddp_pkg::ptddp_mask_t      nonempty_w;
  ptddp_pkg::ptddp_sig_t       sig_w [NL];
  logic [NL*`PTDDP_LVL_W-1:0]  lvl_flat_w;

  // register decode
  wire wr_ctrl  = reg_wr && (reg_addr == `PTDDP_REG_CTRL);
  wire wr_err   = reg_wr && (reg_addr == `PTDDP_REG_ERR);
  wire [2:0] lane0_sel = ctrl_r[2:0];
  wire dsk_en   = ctrl_r[`PTDDP_CTRL_EN_BIT];
  wire ptddp_pkg::ptddp_mask_t err_clr = wr_err ? reg_wdata[NL-1:0] : '0;
  wire [31:0] rd_mux =
    (reg_addr == `PTDDP_REG_CTRL) ? {28'h0, ctrl_r} :
    (reg_addr == `PTDDP_REG_ERR)  ? {24'h0, err_r} :
    (reg_addr == `PTDDP_REG_STAT) ? {15'h0, ltssm_state,
                                     width_onehot(lane_width_code), ts_cnt_r} :
    32'h0;

  // training-state view
  wire idle_win  = (ltssm_state == `PTDDP_ST_CFG_IDLE) ||
                   (ltssm_state == `PTDDP_ST_REC_IDLE);
  wire state_chg = (ltssm_state != state_prev_r);
  wire ts0_done  = ts_done_w[lane0_sel];
  wire ts_hit    = ts0_done && have_prev_r && (sig_w[lane0_sel] == prev_sig_r);
  wire rd_all    = dsk_en && (&nonempty_w);

  // lane n always lands on bit n of every one-bit per-lane field and on bits 3n to 3n+2 of the level field
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      wire sym_wr = sym_valid[g];
      // full and no read in the same cycle: the word is lost
      assign ovf_w[g]      = sym_wr && !rd_all && (lvl_r[g] == `PTDDP_FIFO_DEPTH);
      assign nonempty_w[g] = (lvl_r[g] != 3'h0);
      assign lvl_flat_w[g*`PTDDP_LVL_W +: `PTDDP_LVL_W] = lvl_r[g];

      ptddp_lane_rx u_rx (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .sym_valid (sym_valid[g]),
        .sym_data  (sym_data[g*`PTDDP_SYM_W +: `PTDDP_SYM_W]),
        .sym_is_k  (sym_is_k[g]),
        .idle_win  (idle_win),
        .idle_seen (idle_seen_w[g]),
        .ts_done   (ts_done_w[g]),
        .link_pad  (link_pad_w[g]),
        .lane_pad  (lane_pad_w[g]),
        .ts_sig    (sig_w[g])
      );

      ptddp_fifo_mem u_mem (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (sym_wr && !ovf_w[g]),
        .wr_addr  (wptr_r[g]),
        .wr_data  ({sym_is_k[g], sym_data[g*`PTDDP_SYM_W +: `PTDDP_SYM_W]}),
        .rd_en    (rd_all),
        .rd_addr  (rptr_r[g]),
        .rd_data  (dsk_data[g*`PTDDP_ENT_W +: `PTDDP_ENT_W])
      );

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          lvl_r[g]  <= '0;
          wptr_r[g] <= '0;
          rptr_r[g] <= '0;
        end else begin
          lvl_r[g] <= level_next(lvl_r[g], sym_wr && !ovf_w[g], rd_all);
          if (sym_wr && !ovf_w[g]) begin
            wptr_r[g] <= wptr_r[g] + 2'h1;
          end
          if (rd_all) begin
            rptr_r[g] <= rptr_r[g] + 2'h1;
          end
        end
      end
    end
  endgenerate

  wire [127:0] dbg_nxt = {err_r, lvl_flat_w, `PTDDP_RSVD_ZERO,
                          width_onehot(lane_width_code), ts_cnt_r,
                          lane_pad_w, link_pad_w, idle_seen_w, idle_seen_w,
                          `PTDDP_GAP_ZERO, ltssm_state};

  // registers; a new overflow beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r    <= `PTDDP_CTRL_RST;
      err_r     <= '0;
      reg_rdata <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[3:0];
      end
      err_r     <= (err_r & ~err_clr) | ovf_w;
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // identical-set run count, restarted on every state change
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_prev_r <= '0;
      ts_cnt_r     <= '0;
      prev_sig_r   <= '0;
      have_prev_r  <= 1'b0;
    end else begin
      state_prev_r <= ltssm_state;
      if (state_chg) begin
        ts_cnt_r    <= '0;
        have_prev_r <= 1'b0;
      end else if (ts0_done) begin
        // natural 8-bit overflow gives the wrap to zero
        ts_cnt_r    <= ts_hit ? ts_cnt_r + 8'h1 : 8'h1;
        prev_sig_r  <= sig_w[lane0_sel];
        have_prev_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dbg_out     <= '0;
      dsk_valid   <= 1'b0;
      retrain_req <= 1'b0;
      rx_port_err <= 1'b0;
    end else begin
      dbg_out     <= dbg_nxt;
      dsk_valid   <= rd_all;
      retrain_req <= |ovf_w;
      rx_port_err <= |ovf_w;
    end
  end

  a_idle_field: assert property (@(posedge core_clk) disable iff (!resetn)
    dbg_out[`PTDDP_FLD_IDLE_A +: NL] == $past(idle_seen_w) &&
    dbg_out[`PTDDP_FLD_IDLE_B +: NL] == dbg_out[`PTDDP_FLD_IDLE_A +: NL])
    else $error("idle flags do not follow the lane detectors");

  a_idle_outside: assert property (@(posedge core_clk) disable iff (!resetn)
    !idle_win |-> ##2 dbg_out[`PTDDP_FLD_IDLE_A +: NL] == '0)
    else $error("idle flags set outside the idle states");

  a_link_pad: assert property (@(posedge core_clk) disable iff (!resetn)
    dbg_out[`PTDDP_FLD_LINKPAD +: NL] == $past(link_pad_w))
    else $error("link pad field wrong");

  a_lane_pad: assert property (@(posedge core_clk) disable iff (!resetn)
    dbg_out[`PTDDP_FLD_LANEPAD +: NL] == $past(lane_pad_w))
    else $error("lane pad field wrong");

  a_ts_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
    (!state_chg && ts_hit && ts_cnt_r == 8'hFF) |=> ts_cnt_r == 8'h00 ##1
    dbg_out[`PTDDP_FLD_TSNUM +: 8] == 8'h00)
    else $error("identical set count did not wrap");

  a_ts_restart: assert property (@(posedge core_clk) disable iff (!resetn)
    state_chg |=> ts_cnt_r == 8'h00)
    else $error("identical set count not cleared on state change");

  // first edge after release still shows the cleared bus
  a_width_code: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(resetn) |-> dbg_out[`PTDDP_FLD_WIDTH +: 4] == (4'h1 << $past(lane_width_code)) &&
    $onehot(dbg_out[`PTDDP_FLD_WIDTH +: 4]))
    else $error("lane width code not one-hot");

  a_fifo_level: assert property (@(posedge core_clk) disable iff (!resetn)
    dbg_out[`PTDDP_FLD_LEVEL +: NL*`PTDDP_LVL_W] == $past(lvl_flat_w) &&
    lvl_r[0] <= `PTDDP_FIFO_DEPTH)
    else $error("deskew level field wrong");

  a_ovf_retrain: assert property (@(posedge core_clk) disable iff (!resetn)
    (|ovf_w) |=> retrain_req && rx_port_err ##1
    ((dbg_out[`PTDDP_FLD_DSKERR +: NL] & $past(ovf_w, 2)) == $past(ovf_w, 2)))
    else $error("overflow not reported");

  a_state_code: assert property (@(posedge core_clk) disable iff (!resetn)
    dbg_out[`PTDDP_FLD_STATE +: 5] == $past(ltssm_state))
    else $error("state code field wrong");
endmodule // ptddp_top

// [tb/ptddp_dbg_sniffer.sv]
// user-side debug sampler that polices the fixed parts of the test-out bus
`timescale 1ns/10ps
module ptddp_dbg_sniffer (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // observed debug bus
  input  wire logic [127:0] dbg_out,
  // violations seen since reset
  output logic      [15:0]  bad_cnt
);
  logic bad;
  // unused bits read zero, both idle copies agree, sampled every cycle
  assign bad = (dbg_out[47:5] !== 43'h0) || (dbg_out[95:92] !== 4'h0) ||
               (dbg_out[63:56] !== dbg_out[55:48]);
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bad_cnt <= 16'h0000;
    end else if (bad) begin
      bad_cnt <= bad_cnt + 16'h0001;
    end
  end
endmodule // ptddp_dbg_sniffer

// [tb/testbench.sv]
// self-checking bench for the training and deskew debug probe
`timescale 1ns/10ps
`include "ptddp_map.svh"
module testbench;
  logic                     core_clk, resetn, reg_wr, reg_rd, dsk_valid, retrain_req, rx_port_err;
  logic [3:0]               reg_addr;
  logic [31:0]              reg_wdata, reg_rdata, v;
  ptddp_pkg::ptddp_state_t  ltssm_state;
  ptddp_pkg::ptddp_width_t  lane_width_code;
  logic [7:0]               sym_valid, sym_is_k;
  logic [63:0]              sym_data;
  logic [71:0]              dsk_data;
  logic [127:0]             dbg_out;
  logic [15:0]              bad_cnt;
  logic [23:0]              e1, e2;
  int                       num_errors, n_compared, cyc;

  ptddp_top i_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ltssm_state(ltssm_state), .lane_width_code(lane_width_code), .sym_valid(sym_valid),
    .sym_data(sym_data), .sym_is_k(sym_is_k), .dsk_valid(dsk_valid), .dsk_data(dsk_data),
    .retrain_req(retrain_req), .rx_port_err(rx_port_err), .dbg_out(dbg_out));
  ptddp_dbg_sniffer i_sniff (.core_clk(core_clk), .resetn(resetn), .dbg_out(dbg_out),
    .bad_cnt(bad_cnt));

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hung handshake ends the run here
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    sym_valid <= 8'h00;
    ltssm_state <= 5'h00;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic sym(input logic [63:0] d, input logic [7:0] k, input logic [7:0] vm);
    @(posedge core_clk);
    sym_data <= d;
    sym_is_k <= k;
    sym_valid <= vm;
  endtask

  task automatic settle();
    sym(64'h0, 8'h00, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic fin(input string name);
    chk(bad_cnt, 16'h0000);
    $display("test %s finished", name);
  endtask

  // one training set on all lanes; lane 0 link field is l0 unless padded
  task automatic ts(input logic [7:0] lp, input logic [7:0] np, input logic [7:0] l0,
                    input logic [7:0] id);
    logic [63:0] d;
    logic [7:0]  k;
    for (int s = 0; s < 16; s++) begin
      for (int n = 0; n < 8; n++) begin
        k[n] = (s == 0) || (s == 1 && lp[n]) || (s == 2 && np[n]);
        case (s)
          0: d[8*n+:8] = `PTDDP_K_COM;
          1: d[8*n+:8] = lp[n] ? `PTDDP_K_PAD : ((n == 0) ? l0 : 8'h01);
          2: d[8*n+:8] = np[n] ? `PTDDP_K_PAD : 8'(n);
          3, 4, 5: d[8*n+:8] = 8'h20;
          default: d[8*n+:8] = id;
        endcase
      end
      sym(d, k, 8'hFF);
    end
  endtask

  task automatic test_regs();
    do_reset();
    #1 chk(dbg_out, 128'h0);
    reg_read(4'h0);
    chk(v, 32'h8);
    // read data stand for one cycle only
    @(posedge core_clk);
    #1 chk(reg_rdata, 32'h0);
    reg_read(4'h4);
    chk(v, 32'h0);
    reg_write(4'hC, 32'hFFFF_FFFF);
    reg_read(4'hC);
    chk(v, 32'h0);
    reg_read(4'h0);
    chk(v, 32'h8);
    fin("regs");
  endtask

  task automatic test_width();
    do_reset();
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      lane_width_code <= 2'(c);
      ltssm_state <= 5'(5'h10 + c);
      repeat (3) @(posedge core_clk);
      #1 chk(dbg_out[91:88], 4'h1 << c);
      chk(dbg_out[4:0], 5'h10 + c);
      reg_read(4'h8);
      chk(v[16:12], 5'h10 + c);
      chk(v[11:8], 4'h1 << c);
    end
    fin("width");
  endtask

  // lane 5 carries a non-idle byte, so its flag must stay low
  task automatic test_idle();
    logic [4:0] st;
    do_reset();
    for (int i = 0; i < 2; i++) begin
      st = (i == 0) ? `PTDDP_ST_CFG_IDLE : `PTDDP_ST_REC_IDLE;
      @(posedge core_clk);
      ltssm_state <= st;
      repeat (8) sym(64'h0000_0100_0000_0000, 8'h00, 8'hFF);
      sym(64'h0, 8'h00, 8'h00);
      #1 chk(dbg_out[63:48], 16'h0);
      repeat (2) @(posedge core_clk);
      #1 chk(dbg_out[63:48], 16'hDFDF);
      chk(dbg_out[4:0], st);
      @(posedge core_clk);
      ltssm_state <= 5'h0F;
      repeat (3) @(posedge core_clk);
      #1 chk(dbg_out[63:48], 16'h0);
    end
    fin("idle");
  endtask

  task automatic test_ts();
    do_reset();
    @(posedge core_clk);
    ltssm_state <= 5'h07;
    ts(8'hA5, 8'h3C, 8'h01, `PTDDP_TS1_ID);
    settle();
    chk(dbg_out[79:64], 16'h3CA5);
    chk(dbg_out[87:80], 8'h01);
    repeat (254) ts(8'hA5, 8'h3C, 8'h01, `PTDDP_TS1_ID);
    settle();
    chk(dbg_out[87:80], 8'hFF);
    ts(8'hA5, 8'h3C, 8'h01, `PTDDP_TS1_ID);
    settle();
    chk(dbg_out[87:80], 8'h00);
    ts(8'h00, 8'h00, 8'h01, 8'h11);
    settle();
    chk(dbg_out[87:64], 24'h003CA5);
    ts(8'h00, 8'h00, 8'h02, `PTDDP_TS2_ID);
    settle();
    chk(dbg_out[87:64], 24'h010000);
    // lane 1 as logical lane zero: lane 0 alone would have counted to 3
    reg_write(4'h0, 32'h9);
    repeat (2) ts(8'h00, 8'h00, 8'h02, `PTDDP_TS2_ID);
    settle();
    chk(dbg_out[87:80], 8'h02);
    @(posedge core_clk);
    ltssm_state <= 5'h0F;
    repeat (3) @(posedge core_clk);
    #1 chk(dbg_out[87:80], 8'h00);
    fin("ts");
  endtask

  task automatic test_deskew();
    do_reset();
    reg_write(4'h0, 32'h0);
    for (int n = 0; n < 8; n++) begin
      e1[3*n+:3] = 3'((n > 4) ? 4 : n);
      e2[3*n+:3] = (n == 0) ? 3'h0 : e1[3*n+:3] - 3'h1;
    end
    for (int j = 0; j < 4; j++) begin
      sym({8{8'(8'h10 + j)}}, 8'h00, 8'hFF << (j + 1));
    end
    settle();
    chk(dbg_out[119:96], e1);
    sym({8{8'h33}}, 8'h00, 8'h40);
    sym(64'h0, 8'h00, 8'h00);
    #1 chk({retrain_req, rx_port_err}, 2'b11);
    @(posedge core_clk);
    #1 chk({retrain_req, rx_port_err}, 2'b00);
    chk(dbg_out[127:120], 8'h40);
    chk(dbg_out[119:96], e1);
    reg_read(4'h4);
    chk(v, 32'h40);
    reg_write(4'h4, 32'h40);
    reg_read(4'h4);
    chk(v, 32'h0);
    reg_write(4'h0, 32'h8);
    sym(64'h5A, 8'h00, 8'h01);
    sym(64'h0, 8'h00, 8'h00);
    for (int t = 0; t < 6 && dsk_valid !== 1'b1; t++) begin
      @(posedge core_clk);
      #1;
    end
    chk(dsk_valid, 1'b1);
    chk(dsk_data[17:0], {9'h010, 9'h05A});
    repeat (2) @(posedge core_clk);
    #1 chk(dbg_out[119:96], e2);
    fin("deskew");
  endtask

  initial begin
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ltssm_state = 5'h00;
    lane_width_code = 2'h0;
    sym_valid = 8'h00;
    sym_data = 64'h0;
    sym_is_k = 8'h00;
    test_regs();
    test_width();
    test_idle();
    test_ts();
    test_deskew();
    summarize();
  end
endmodule // testbench
